// >>> iopri_fabric.sv
`timescale 1ns/1ps
`default_nettype none
module iopri_fabric (
    // Mode and driven values
    input  wire logic       feed,
    input  wire logic [7:0] drv_data,
    input  wire logic [3:0] drv_oe,
    // Port connections
    input  wire logic [7:0] fab_in,
    output logic [7:0]      fab_out,
    output logic [3:0]      fab_oe
);
    // Pin-to-pin logic feed-through, or data driven by the bench
    assign fab_out = feed ? fab_in : drv_data;
    // Enables change cycle by cycle under bench control
    assign fab_oe = drv_oe;
endmodule : iopri_fabric
`default_nettype wire

// >>> iopri_pkg.sv
`default_nettype none
package iopri_pkg;
    // Register byte offsets
    localparam logic [11:0] IOPRI_IN_SYNC_OFS  = 12'h000;
    localparam logic [11:0] IOPRI_OUT_REG_OFS  = 12'h004;
    localparam logic [11:0] IOPRI_OE_MAP_OFS   = 12'h008;
    localparam logic [11:0] IOPRI_PIN_STAT_OFS = 12'h00c;
    localparam logic [11:0] IOPRI_FAB_STAT_OFS = 12'h010;

    // Reset values
    localparam logic [7:0]  IOPRI_IN_SYNC_RST = 8'hff;
    localparam logic [7:0]  IOPRI_OUT_REG_RST = 8'h00;
    localparam logic [15:0] IOPRI_OE_MAP_RST  = 16'h0000;
    localparam logic [7:0]  IOPRI_FLOP_RST    = 8'h00;

    // Enable map field layout
    localparam int IOPRI_OE_SEL_W = 2;

    // Register bus states
    typedef enum logic [1:0] {
        IOPRI_BUS_IDLE   = 2'b00,
        IOPRI_BUS_SETUP  = 2'b01,
        IOPRI_BUS_ACCESS = 2'b10
    } iopri_bus_t;
endpackage : iopri_pkg
`default_nettype wire

// >>> iopri_top.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module iopri_top
    import iopri_pkg::*;
#(
    parameter int PINS = 8,
    parameter int OES  = 4
) (
    // System clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Routing fabric side
    input  wire logic [PINS-1:0] fab_out,
    input  wire logic [OES-1:0]  fab_oe,
    output logic [PINS-1:0]      fab_in,
    // Pin driver and receiver side
    input  wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0]      pin_out,
    output logic [PINS-1:0]      pin_oe
);

    // Refuse shapes the register map cannot hold
    generate
        if (PINS != 8 || OES != 4) begin : g_bad_shape
            $error("iopri_top: only an eight-pin port with four enables fits");
        end
    endgenerate

    // Enable map width: one select field per pin
    localparam int OE_MAP_W = PINS * IOPRI_OE_SEL_W;

    // Configuration and pipeline state
    logic [PINS-1:0]     in_sync_r;
    logic [PINS-1:0]     out_reg_r;
    logic [OE_MAP_W-1:0] oe_map_r;
    logic [PINS-1:0]     sync1_r;
    logic [PINS-1:0]     sync2_r;
    logic [PINS-1:0]     opipe_r;
    logic [31:0]         prdata_r;
    iopri_bus_t          bus_r;
    iopri_bus_t          bus_nxt;

    // Address decode shared by read, write and error logic
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = reg_hit(a, IOPRI_IN_SYNC_OFS) || reg_hit(a, IOPRI_OUT_REG_OFS)
                   || reg_hit(a, IOPRI_OE_MAP_OFS) || reg_hit(a, IOPRI_PIN_STAT_OFS)
                   || reg_hit(a, IOPRI_FAB_STAT_OFS);
    endfunction : addr_mapped

    logic wr_en;
    logic rd_setup;

    // Write commits at the access edge; read data is latched in setup
    assign wr_en    = psel && penable && pwrite && addr_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    // Bus phase tracking
    always_comb begin
        bus_nxt = IOPRI_BUS_IDLE;
        case (bus_r)
            IOPRI_BUS_IDLE:   bus_nxt = psel ? IOPRI_BUS_SETUP : IOPRI_BUS_IDLE;
            IOPRI_BUS_SETUP:  bus_nxt = IOPRI_BUS_ACCESS;
            IOPRI_BUS_ACCESS: bus_nxt = (psel && !penable) ? IOPRI_BUS_SETUP : IOPRI_BUS_IDLE;
            default:          bus_nxt = IOPRI_BUS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_r <= IOPRI_BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata  = prdata_r;

    // Synchroniser selection, one bit per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sync_r <= IOPRI_IN_SYNC_RST;
        end else if (wr_en && reg_hit(paddr, IOPRI_IN_SYNC_OFS)) begin
            in_sync_r <= pwdata[PINS-1:0];
        end
    end

    // Output register selection, one bit per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg_r <= IOPRI_OUT_REG_RST;
        end else if (wr_en && reg_hit(paddr, IOPRI_OUT_REG_OFS)) begin
            out_reg_r <= pwdata[PINS-1:0];
        end
    end

    // Enable source per pin, two bits each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_map_r <= IOPRI_OE_MAP_RST;
        end else if (wr_en && reg_hit(paddr, IOPRI_OE_MAP_OFS)) begin
            oe_map_r <= pwdata[OE_MAP_W-1:0];
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= 32'h0000_0000;
            if (reg_hit(paddr, IOPRI_IN_SYNC_OFS)) begin
                prdata_r[PINS-1:0] <= in_sync_r;
            end else if (reg_hit(paddr, IOPRI_OUT_REG_OFS)) begin
                prdata_r[PINS-1:0] <= out_reg_r;
            end else if (reg_hit(paddr, IOPRI_OE_MAP_OFS)) begin
                prdata_r[OE_MAP_W-1:0] <= oe_map_r;
            end else if (reg_hit(paddr, IOPRI_PIN_STAT_OFS)) begin
                prdata_r[PINS-1:0] <= sync2_r; // Only the second stage is read
            end else if (reg_hit(paddr, IOPRI_FAB_STAT_OFS)) begin
                prdata_r[PINS-1:0] <= pin_oe;
            end
        end
    end

    // Two-flop input synchroniser on the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= IOPRI_FLOP_RST;
            sync2_r <= IOPRI_FLOP_RST;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Input into the fabric: synchronised or raw per pin
    assign fab_in = (in_sync_r & sync2_r) | (~in_sync_r & pin_in);

    // Single output pipeline stage on the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opipe_r <= IOPRI_FLOP_RST;
        end else begin
            opipe_r <= fab_out;
        end
    end

    // Output data: registered or direct per pin
    assign pin_out = (out_reg_r & opipe_r) | (~out_reg_r & fab_out);

    // Each pin takes its enable from one of the four dynamic lines
    always_comb begin
        pin_oe = '0;
        for (int i = 0; i < PINS; i++) begin
            pin_oe[i] = fab_oe[oe_map_r[i*IOPRI_OE_SEL_W +: IOPRI_OE_SEL_W]];
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sync_path_a: assert property (
        (in_sync_r == '1) && ($past(in_sync_r) == '1) && $past(presetn, 2)
        |-> fab_in == $past(pin_in, 2))
        else $error("synchronised input does not lag the pin by two cycles");

    in_bypass_a: assert property (
        (in_sync_r == '0) |-> fab_in == pin_in)
        else $error("bypassed input differs from the pin");

    out_pipe_a: assert property (
        (out_reg_r == '1) && $past(presetn) |-> pin_out == $past(fab_out))
        else $error("registered output does not lag the fabric by one cycle");

    feed_through_a: assert property (
        (in_sync_r == '0) && (out_reg_r == '0) |-> pin_out == fab_out)
        else $error("full bypass is not combinational");

    oe_gang_a: assert property (
        (oe_map_r == '0) |-> pin_oe == {PINS{fab_oe[0]}})
        else $error("ganged enable does not follow the first line");

    oe_single_a: assert property (
        (oe_map_r[7:0] == 8'he4) |-> pin_oe[3:0] == fab_oe)
        else $error("individual enables do not follow their lines");

    reset_values_a: assert property (
        !$past(presetn) |-> (in_sync_r == '1) && (out_reg_r == '0) && (opipe_r == '0))
        else $error("state after reset is wrong");

    cfg_write_a: assert property (
        wr_en && reg_hit(paddr, IOPRI_IN_SYNC_OFS)
        |=> in_sync_r == $past(pwdata[PINS-1:0]))
        else $error("synchroniser selection write lost");

    bus_answer_a: assert property (
        psel && !penable ##1 psel && penable |-> pready && (pslverr == !addr_mapped(paddr)))
        else $error("access phase answer wrong");

    // Bus phase: the tracked phase is that of the cycle just ended
    access_order_a: assert property (
        pready
        |-> bus_r == IOPRI_BUS_SETUP)
        else $error("access phase without a preceding setup");

    setup_step_a: assert property (
        bus_r == IOPRI_BUS_SETUP
        |=> bus_r == IOPRI_BUS_ACCESS)
        else $error("bus phase tracking skipped the access state");

    idle_quiet_a: assert property (
        !(psel && penable)
        |-> !pready && !pslverr)
        else $error("bus answer outside an access phase");

    // Read data: the setup-edge value stands through the access cycle
    rd_in_sync_a: assert property (
        psel && !penable && !pwrite && reg_hit(paddr, IOPRI_IN_SYNC_OFS)
        |=> prdata[PINS-1:0] == $past(in_sync_r))
        else $error("read of the synchroniser selection is wrong");

    rd_out_reg_a: assert property (
        psel && !penable && !pwrite && reg_hit(paddr, IOPRI_OUT_REG_OFS)
        |=> prdata[PINS-1:0] == $past(out_reg_r))
        else $error("read of the output register selection is wrong");

    rd_oe_map_a: assert property (
        psel && !penable && !pwrite && reg_hit(paddr, IOPRI_OE_MAP_OFS)
        |=> prdata[OE_MAP_W-1:0] == $past(oe_map_r))
        else $error("read of the enable map is wrong");

    rd_pin_stat_a: assert property (
        psel && !penable && !pwrite && reg_hit(paddr, IOPRI_PIN_STAT_OFS)
        |=> prdata[PINS-1:0] == $past(sync2_r))
        else $error("read of the synchronised pin levels is wrong");

    rd_oe_stat_a: assert property (
        psel && !penable && !pwrite && reg_hit(paddr, IOPRI_FAB_STAT_OFS)
        |=> prdata[PINS-1:0] == $past(pin_oe))
        else $error("read of the pin enables is wrong");

    rd_unmapped_a: assert property (
        psel && !penable && !pwrite && !addr_mapped(paddr)
        |=> prdata == '0)
        else $error("read of an unmapped address is not zero");

    prdata_upper_a: assert property (
        prdata[31:OE_MAP_W] == '0)
        else $error("unused read data bits are not zero");

    // Configuration writes land only where they are aimed
    cfg_out_reg_a: assert property (
        wr_en && reg_hit(paddr, IOPRI_OUT_REG_OFS)
        |=> out_reg_r == $past(pwdata[PINS-1:0]))
        else $error("output register selection write lost");

    cfg_oe_map_a: assert property (
        wr_en && reg_hit(paddr, IOPRI_OE_MAP_OFS)
        |=> oe_map_r == $past(pwdata[OE_MAP_W-1:0]))
        else $error("enable map write lost");

    cfg_hold_a: assert property (
        !(psel && penable && pwrite)
        |=> $stable(in_sync_r) && $stable(out_reg_r) && $stable(oe_map_r))
        else $error("configuration changed without a write");

    err_write_a: assert property (
        psel && penable && pwrite && !addr_mapped(paddr)
        |=> $stable(in_sync_r) && $stable(out_reg_r) && $stable(oe_map_r))
        else $error("write to an unmapped address changed state");

    ro_write_a: assert property (
        psel && penable && pwrite
        && (reg_hit(paddr, IOPRI_PIN_STAT_OFS) || reg_hit(paddr, IOPRI_FAB_STAT_OFS))
        |=> $stable(in_sync_r) && $stable(out_reg_r) && $stable(oe_map_r))
        else $error("write to a status register changed state");

    // Flops behind the selectable paths
    sync_first_a: assert property (
        $past(presetn)
        |-> sync1_r == $past(pin_in))
        else $error("first synchroniser stage missed the pin");

    sync_second_a: assert property (
        $past(presetn)
        |-> sync2_r == $past(sync1_r))
        else $error("second synchroniser stage missed the first");

    opipe_track_a: assert property (
        $past(presetn)
        |-> opipe_r == $past(fab_out))
        else $error("output pipeline stage missed the fabric");

    reset_flops_a: assert property (
        !$past(presetn)
        |-> (sync1_r == '0) && (sync2_r == '0) && (oe_map_r == '0) && (prdata == '0))
        else $error("flops not cleared by reset");

    // Per-pin path checks, so a mixed selection is covered bit by bit
    for (genvar i = 0; i < PINS; i++) begin : g_pin_chk
        pin_in_sync_a: assert property (
            in_sync_r[i] && $past(presetn) && $past(presetn, 2)
            |-> fab_in[i] == $past(pin_in[i], 2))
            else $error("synchronised pin input does not lag by two cycles");

        pin_in_raw_a: assert property (
            !in_sync_r[i]
            |-> fab_in[i] == pin_in[i])
            else $error("bypassed pin input differs from the pin");

        pin_out_reg_a: assert property (
            out_reg_r[i] && $past(presetn)
            |-> pin_out[i] == $past(fab_out[i]))
            else $error("registered pin output does not lag by one cycle");

        pin_out_raw_a: assert property (
            !out_reg_r[i]
            |-> pin_out[i] == fab_out[i])
            else $error("direct pin output differs from the fabric");

        pin_oe_own_a: assert property (
            (oe_map_r[i*IOPRI_OE_SEL_W +: IOPRI_OE_SEL_W] == IOPRI_OE_SEL_W'(i % OES))
            |-> pin_oe[i] == fab_oe[i % OES])
            else $error("pin enable does not follow its own line");
    end

endmodule : iopri_top
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import iopri_pkg::*; ();
    // Bus, fabric and pad signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, feed, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  fab_out, fab_in, pin_in, pin_out, pin_oe, drv, s1, s2, q, ins, outr;
    logic [7:0]  e_in, e_out, e_oe;
    logic [3:0]  fab_oe, doe;
    logic [15:0] map;
    int          num_errors, checks_done;
    // Configuration table: input sync, output register, enable map
    logic [7:0]  t_in [6] = '{8'hff, 8'h00, 8'h5a, 8'h0f, 8'h00, 8'h00};
    logic [7:0]  t_out [6] = '{8'h00, 8'hff, 8'ha5, 8'hf0, 8'h00, 8'h00};
    logic [15:0] t_map [6] = '{16'h0000, 16'h00e4, 16'h1b1b, 16'h5555, 16'h0000, 16'h00e4};

    iopri_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fab_out(fab_out), .fab_oe(fab_oe), .fab_in(fab_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    iopri_fabric fab (.feed(feed), .drv_data(drv), .drv_oe(doe), .fab_in(fab_in),
        .fab_out(fab_out), .fab_oe(fab_oe));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Reference synchroniser and pipeline flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            q  <= 8'h00;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            q  <= fab_out;
        end
    end

    // Expected port outputs
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            e_in[i]  = ins[i] ? s2[i] : pin_in[i];
            e_out[i] = outr[i] ? q[i] : fab_out[i];
            e_oe[i]  = fab_oe[map[2*i +: 2]];
        end
    end

    // Random pad and fabric traffic
    always @(posedge pclk) begin
        if (run) begin
            pin_in <= 8'($urandom);
            drv    <= 8'($urandom);
            doe    <= 4'($urandom);
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // Compare every cycle, away from the clock edge
    always @(negedge pclk) begin
        chk({24'h0, fab_in}, {24'h0, e_in}, "fab_in");
        chk({24'h0, pin_out}, {24'h0, e_out}, "pin_out");
        chk({24'h0, pin_oe}, {24'h0, e_oe}, "pin_oe");
        if (feed && ins == 8'h00 && outr == 8'h00) chk(pin_out, pin_in, "thru");
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "apb timeout");
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, d, r, err);
        chk({31'h0, err}, {31'h0, ee}, "wr err");
        if (a == IOPRI_IN_SYNC_OFS) ins = d[7:0];
        if (a == IOPRI_OUT_REG_OFS) outr = d[7:0];
        if (a == IOPRI_OE_MAP_OFS) map = d[15:0];
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic        err;
        apb(1'b0, a, 32'h0, r, err);
        chk(r, e, "rd data");
        chk({31'h0, err}, {31'h0, ee}, "rd err");
    endtask : rd

    task automatic do_reset();
        presetn <= 1'b0;
        ins  = IOPRI_IN_SYNC_RST;
        outr = IOPRI_OUT_REG_RST;
        map  = IOPRI_OE_MAP_RST;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Watchdog
    initial begin
        #100000;
        num_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, feed, run} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {pin_in, drv, doe} = 20'h00000;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(27));
        do_reset();
        for (int k = 0; k < 6; k++) begin
            rd(IOPRI_IN_SYNC_OFS, {24'h0, ins}, 1'b0);
            rd(IOPRI_OUT_REG_OFS, {24'h0, outr}, 1'b0);
            rd(IOPRI_OE_MAP_OFS, {16'h0, map}, 1'b0);
            rd(12'h014, 32'h0, 1'b1);
            wr(12'h014, $urandom, 1'b1);
            wr(IOPRI_PIN_STAT_OFS, 32'hffffffff, 1'b0);
            wr(IOPRI_IN_SYNC_OFS, (k == 4) ? $urandom : {24'h0, t_in[k]}, 1'b0);
            wr(IOPRI_OUT_REG_OFS, (k == 4) ? $urandom : {24'h0, t_out[k]}, 1'b0);
            wr(IOPRI_OE_MAP_OFS, (k == 4) ? $urandom : {16'h0, t_map[k]}, 1'b0);
            feed <= (k == 5);
            run  <= 1'b1;
            repeat (150) @(posedge pclk);
            if (k == 2) do_reset();
            run <= 1'b0;
            repeat (3) @(posedge pclk);
            rd(IOPRI_FAB_STAT_OFS, {24'h0, e_oe}, 1'b0);
            rd(IOPRI_PIN_STAT_OFS, {24'h0, s2}, 1'b0);
        end
        summarize();
    end
endmodule : tb
`default_nettype wire
